// [frtm_pkg.sv]
// Shared constants for the fan ramp limiter and throttle monitor.
// Assumes a single 200 MHz clock and byte-wide register access.
package frtm_pkg;

   // Clock rate, used to turn documented times into cycle counts.
   localparam int CLK_KHZ = 200000;

   // Register offsets.
   localparam logic [7:0] ADDR_INT_STATUS_TWO = 8'h42;
   localparam logic [7:0] ADDR_ACOUSTIC_ONE = 8'h62;
   localparam logic [7:0] ADDR_ACOUSTIC_TWO = 8'h63;
   localparam logic [7:0] ADDR_CONFIG_THREE = 8'h78;
   localparam logic [7:0] ADDR_THROTTLE_STATUS = 8'h79;
   localparam logic [7:0] ADDR_THROTTLE_MASK = 8'h7A;

   // Reset values.
   localparam logic [7:0] RST_ACOUSTIC = 8'h00;
   localparam logic [7:0] RST_CONFIG = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_DUTY = 8'hFF;
   localparam logic [7:0] DUTY_FULL = 8'hFF;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Field positions.
   localparam int BIT_EN_ONE = 3;
   localparam int BIT_EN_TWO = 7;
   localparam int BIT_EN_THREE = 3;
   localparam int STEP_LO_ONE = 0;
   localparam int STEP_LO_TWO = 4;
   localparam int STEP_LO_THREE = 0;
   localparam int BIT_INPUT_SELECT = 1;
   localparam int BIT_FULL_ON = 2;
   localparam int BIT_ASSERT_FLAG = 7;
   localparam int BIT_RELEASE_FLAG = 6;
   localparam int BIT_LONG_FLAG = 5;
   localparam int TIMER_WIDTH = 6;
   localparam logic [5:0] TIMER_MAX = 6'h3F;

   // Duration timer tick of 125 ms.
   localparam int TIMER_TICK_MS = 125;
   localparam int TIMER_TICK_CYCLES = TIMER_TICK_MS * CLK_KHZ;

   // Throttle monitor states.
   typedef enum logic {THR_IDLE, THR_TIMING} frtm_thr_state_type;

   // Ramp step in timeslots for each three-bit code.
   function automatic logic [7:0] frtm_step_of(input logic [2:0] code);
      case (code)
         3'h0: frtm_step_of = 8'h01;
         3'h1: frtm_step_of = 8'h02;
         3'h2: frtm_step_of = 8'h03;
         3'h3: frtm_step_of = 8'h05;
         3'h4: frtm_step_of = 8'h08;
         3'h5: frtm_step_of = 8'h0C;
         3'h6: frtm_step_of = 8'h18;
         default: frtm_step_of = 8'h30;
      endcase
   endfunction

endpackage

// [frtm_ramp_if.sv]
// Interface joining the top module to one ramp limiter channel.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface frtm_ramp_if;
   logic enable;
   logic [2:0] step_code;
   logic [7:0] target;
   logic update;
   logic [7:0] duty;
   modport ctrl (output enable, output step_code, output target,
      output update, input duty);
   modport chan (input enable, input step_code, input target,
      input update, output duty);
endinterface

// [frtm_ramp_chan.sv]
// One duty-cycle ramp limiter channel.
// Assumes update is a one-cycle pulse from same-clock logic.
`timescale 1ns/10ps
module frtm_ramp_chan
   import frtm_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   frtm_ramp_if.chan rif
);

   logic [7:0] duty_q;
   logic [7:0] duty_d;
   logic [7:0] step;
   logic [7:0] diff;

   // Step toward the target but never past it; the previous value
   // is the stored duty itself, so it doubles as the output.
   always_comb begin
      step = frtm_step_of(rif.step_code);
      duty_d = duty_q;
      diff = 8'h00;
      if (rif.update) begin
         if (!rif.enable) begin
            duty_d = rif.target;
         end else if (rif.target > duty_q) begin
            diff = rif.target - duty_q;
            duty_d = (diff < step) ? rif.target : duty_q + step;
         end else if (rif.target < duty_q) begin
            diff = duty_q - rif.target;
            duty_d = (diff < step) ? rif.target : duty_q - step;
         end
      end
   end

   // Stored duty, one timeslot per unit of the 255-slot period.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         duty_q <= RST_DUTY;
      end else begin
         duty_q <= duty_d;
      end
   end

   assign rif.duty = duty_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_ramp_bypass_direct: assert property (
      rif.update && !rif.enable |=> duty_q == $past(rif.target))
      else $error("Disabled ramp did not follow target");
   a_ramp_step_bound: assert property (
      rif.update && rif.enable && rif.target > duty_q |=>
      duty_q - $past(duty_q) == ((($past(rif.target) - $past(duty_q)) <
      frtm_step_of($past(rif.step_code))) ? $past(rif.target) -
      $past(duty_q) : frtm_step_of($past(rif.step_code))))
      else $error("Ramp up step size wrong");
   a_ramp_no_overshoot: assert property (
      rif.update && rif.enable && rif.target < duty_q |=>
      duty_q >= $past(rif.target) && duty_q < $past(duty_q))
      else $error("Ramp down overshot target");

endmodule

// [frtm_top.sv]
// Fan duty ramp limiter for three outputs and the processor
// throttle input monitor with its duration timer and alert.
// Assumes a byte register port driven by a bus engine on clk, a
// duty update pulse from the duty computation, and an async pin.
`timescale 1ns/10ps

module frtm_top
   import frtm_pkg::*;
#(
   parameter int TICK_CYCLES = TIMER_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic duty_update,
   input wire logic [2:0][7:0] target_duty,
   input wire logic cpu_throttle_in_n,
   output logic [2:0][7:0] pwm_duty,
   output logic fan_full_on,
   output logic bus_alert_n
);

   localparam int TICK_W = $clog2(TICK_CYCLES + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   // Software registers.
   logic [7:0] acoustic_ctrl_one_q;
   logic [7:0] acoustic_ctrl_two_q;
   logic [7:0] config_three_q;
   logic [7:0] throttle_mask_limit_q;

   // Throttle monitor state.
   logic thr_sync1_q;
   logic thr_sync2_q;
   logic thr_low_q;
   logic thr_low;
   logic thr_fall;
   logic thr_rise;
   frtm_thr_state_type thr_state_q;
   logic [TICK_W-1:0] tick_cnt_q;
   logic [5:0] throttle_duration_timer_q;
   logic throttle_assert_flag_q;
   logic throttle_release_flag_q;
   logic long_throttle_flag_q;
   logic alert_pend_q;
   logic long_set;
   logic status_rd;
   logic int2_rd;

   // Output registers.
   logic [7:0] reg_rdata_q;
   logic [2:0][7:0] pwm_duty_q;
   logic fan_full_on_q;
   logic bus_alert_n_q;

   // Field views of the registers.
   logic throttle_input_select;
   logic fan_full_on_throttle;
   logic [5:0] throttle_duration_limit;
   logic assert_mask;
   logic release_mask;

   assign throttle_input_select =
      config_three_q[BIT_INPUT_SELECT];
   assign fan_full_on_throttle = config_three_q[BIT_FULL_ON];
   assign throttle_duration_limit =
      throttle_mask_limit_q[TIMER_WIDTH-1:0];
   assign assert_mask = throttle_mask_limit_q[BIT_ASSERT_FLAG];
   assign release_mask = throttle_mask_limit_q[BIT_RELEASE_FLAG];

   // Per-channel enable decode, shared by the generate loop below.
   function automatic logic chan_enable(input int idx,
      input logic [7:0] one, input logic [7:0] two);
      case (idx)
         0: chan_enable = one[BIT_EN_ONE];
         1: chan_enable = two[BIT_EN_TWO];
         default: chan_enable = two[BIT_EN_THREE];
      endcase
   endfunction

   // Per-channel step code decode.
   function automatic logic [2:0] chan_code(input int idx,
      input logic [7:0] one, input logic [7:0] two);
      case (idx)
         0: chan_code = one[STEP_LO_ONE +: 3];
         1: chan_code = two[STEP_LO_TWO +: 3];
         default: chan_code = two[STEP_LO_THREE +: 3];
      endcase
   endfunction

   // Register writes. Status registers are read only, so writes to
   // them are dropped; unmapped writes are dropped too.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acoustic_ctrl_one_q <= RST_ACOUSTIC;
         acoustic_ctrl_two_q <= RST_ACOUSTIC;
         config_three_q <= RST_CONFIG;
         throttle_mask_limit_q <= RST_MASK;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_ACOUSTIC_ONE: acoustic_ctrl_one_q <= reg_wdata;
            ADDR_ACOUSTIC_TWO: acoustic_ctrl_two_q <= reg_wdata;
            ADDR_CONFIG_THREE: config_three_q <= reg_wdata;
            ADDR_THROTTLE_MASK: throttle_mask_limit_q <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   assign status_rd = reg_rd && (reg_addr == ADDR_THROTTLE_STATUS);
   assign int2_rd = reg_rd && (reg_addr == ADDR_INT_STATUS_TWO);

   // Register reads return one cycle after the strobe.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata_q <= READ_ZERO;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_ACOUSTIC_ONE: reg_rdata_q <= acoustic_ctrl_one_q;
            ADDR_ACOUSTIC_TWO: reg_rdata_q <= acoustic_ctrl_two_q;
            ADDR_CONFIG_THREE: reg_rdata_q <= config_three_q;
            ADDR_THROTTLE_MASK: reg_rdata_q <= throttle_mask_limit_q;
            ADDR_THROTTLE_STATUS: reg_rdata_q <= {throttle_assert_flag_q,
               throttle_release_flag_q, throttle_duration_timer_q};
            ADDR_INT_STATUS_TWO: reg_rdata_q <= {2'h0,
               long_throttle_flag_q, 5'h00};
            default: reg_rdata_q <= READ_ZERO;
         endcase
      end
   end

   // Two-stage synchroniser for the throttle pin. The first stage
   // feeds only the second, so metastability cannot reach the edge
   // detector.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         thr_sync1_q <= 1'b1;
         thr_sync2_q <= 1'b1;
      end else begin
         thr_sync1_q <= cpu_throttle_in_n;
         thr_sync2_q <= thr_sync1_q;
      end
   end

   // The pin only counts as throttle while selected; deselecting it
   // while low reads as a release, which keeps the timer honest.
   assign thr_low = throttle_input_select && !thr_sync2_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         thr_low_q <= 1'b0;
      end else begin
         thr_low_q <= thr_low;
      end
   end

   assign thr_fall = thr_low && !thr_low_q;
   assign thr_rise = !thr_low && thr_low_q;

   // Duration measurement: cleared and started on the falling edge,
   // frozen on the rising edge so software can read a stable value.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         thr_state_q <= THR_IDLE;
         tick_cnt_q <= '0;
         throttle_duration_timer_q <= '0;
      end else begin
         case (thr_state_q)
            THR_IDLE: begin
               if (thr_fall) begin
                  thr_state_q <= THR_TIMING;
                  tick_cnt_q <= '0;
                  throttle_duration_timer_q <= '0;
               end
            end
            THR_TIMING: begin
               if (thr_rise) begin
                  thr_state_q <= THR_IDLE;
               end else if (tick_cnt_q == TICK_LAST) begin
                  tick_cnt_q <= '0;
                  if (throttle_duration_timer_q != TIMER_MAX) begin
                     throttle_duration_timer_q <=
                        throttle_duration_timer_q + 6'h01;
                  end
               end else begin
                  tick_cnt_q <= tick_cnt_q + 1'b1;
               end
            end
            default: thr_state_q <= THR_IDLE;
         endcase
      end
   end

   // The limit is compared when the assertion ends, so a short
   // assertion is never reported while it is still running.
   assign long_set = thr_rise &&
      (throttle_duration_timer_q > throttle_duration_limit);

   // Edge flags; a new edge in the cycle of a status read wins.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         throttle_assert_flag_q <= 1'b0;
         throttle_release_flag_q <= 1'b0;
      end else begin
         if (thr_fall) begin
            throttle_assert_flag_q <= 1'b1;
         end else if (status_rd) begin
            throttle_assert_flag_q <= 1'b0;
         end
         if (thr_rise) begin
            throttle_release_flag_q <= 1'b1;
         end else if (status_rd) begin
            throttle_release_flag_q <= 1'b0;
         end
      end
   end

   // Long-throttle flag in interrupt status two, cleared by its read.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         long_throttle_flag_q <= 1'b0;
      end else if (long_set) begin
         long_throttle_flag_q <= 1'b1;
      end else if (int2_rd) begin
         long_throttle_flag_q <= 1'b0;
      end
   end

   // Alert pending: unmasked edges or a long assertion raise it, a
   // status read drops it. Masks do not affect the limit alert.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alert_pend_q <= 1'b0;
      end else if ((thr_fall && !assert_mask) ||
         (thr_rise && !release_mask) || long_set) begin
         alert_pend_q <= 1'b1;
      end else if (status_rd) begin
         alert_pend_q <= 1'b0;
      end
   end

   // Ramp channels, one per fan output.
   frtm_ramp_if ramp_bus [3] ();

   for (genvar i = 0; i < 3; i++) begin : g_chan
      assign ramp_bus[i].enable =
         chan_enable(i, acoustic_ctrl_one_q, acoustic_ctrl_two_q);
      assign ramp_bus[i].step_code =
         chan_code(i, acoustic_ctrl_one_q, acoustic_ctrl_two_q);
      assign ramp_bus[i].target = target_duty[i];
      assign ramp_bus[i].update = duty_update;

      frtm_ramp_chan u_chan (
         .clk(clk),
         .sys_rst(sys_rst),
         .rif(ramp_bus[i])
      );

      // Fan_full_on_throttle overrides the ramped value but leaves the stored
      // duty alone, so the ramp resumes where it was afterwards.
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            pwm_duty_q[i] <= RST_DUTY;
         end else if (fan_full_on_throttle && thr_low) begin
            pwm_duty_q[i] <= DUTY_FULL;
         end else begin
            pwm_duty_q[i] <= ramp_bus[i].duty;
         end
      end
   end

   // Full-on indication and the active-low alert pin.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fan_full_on_q <= 1'b0;
         bus_alert_n_q <= 1'b1;
      end else begin
         fan_full_on_q <= fan_full_on_throttle && thr_low;
         bus_alert_n_q <= !alert_pend_q;
      end
   end

   assign reg_rdata = reg_rdata_q;
   assign pwm_duty = pwm_duty_q;
   assign fan_full_on = fan_full_on_q;
   assign bus_alert_n = bus_alert_n_q;

   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_assert_flag_set: assert property (
      thr_fall |=> throttle_assert_flag_q)
      else $error("Assert flag not set after falling edge");
   a_release_flag_set: assert property (
      thr_rise |=> throttle_release_flag_q && !thr_low_q)
      else $error("Release flag not set after rising edge");
   a_status_read_clear: assert property (
      status_rd && !thr_fall && !thr_rise |=>
      !throttle_assert_flag_q && !throttle_release_flag_q)
      else $error("Status read did not clear edge flags");
   a_timer_frozen_idle: assert property (
      thr_state_q == THR_IDLE && !thr_fall |=>
      $stable(throttle_duration_timer_q))
      else $error("Timer moved while stopped");
   a_timer_saturate: assert property (
      throttle_duration_timer_q == TIMER_MAX && !thr_fall |=>
      throttle_duration_timer_q == TIMER_MAX)
      else $error("Timer wrapped past all ones");
   a_fan_full_on_throttle_full_duty: assert property (
      fan_full_on_throttle && thr_low |=> pwm_duty_q[0] == DUTY_FULL &&
      pwm_duty_q[1] == DUTY_FULL && pwm_duty_q[2] == DUTY_FULL)
      else $error("Fan_full_on_throttle did not force full duty");
   a_long_flag_set: assert property (
      thr_rise && throttle_duration_timer_q > throttle_duration_limit
      |=> long_throttle_flag_q ##1 !bus_alert_n_q)
      else $error("Long throttle not flagged");
   a_alert_on_event: assert property (
      thr_fall && !assert_mask |=> ##1 !bus_alert_n_q)
      else $error("Unmasked assertion gave no alert");
   a_masked_no_alert: assert property (
      !alert_pend_q && thr_fall && assert_mask |=> !alert_pend_q)
      else $error("Masked assertion raised alert");

endmodule

// [frtm_cpu_model.sv]
// Behavioural model of the processor's active-low throttle output.
// Assumes an open-drain pin with a board pull-up, so the idle level is high.
`timescale 1ns/10ps
module frtm_cpu_model (
   input wire logic clk,
   output logic cpu_throttle_in_n
);
   // The pull-up keeps the line high whenever the processor lets go.
   initial begin
      cpu_throttle_in_n = 1'b1;
   end

   // Pulls the line low for a number of clocks, then releases it.
   // Changes land just after an edge so the timing seen is repeatable.
   task automatic hold_low(input int cycles);
      @(posedge clk);
      #1;
      cpu_throttle_in_n = 1'b0;
      repeat (cycles) @(posedge clk);
      #1;
      cpu_throttle_in_n = 1'b1;
   endtask
endmodule

// [frtm_top_bench.sv]
// Self-checking bench for the fan ramp limiter and throttle monitor.
// Assumes the processor model above drives the throttle pin.
`timescale 1ns/10ps
module frtm_top_bench
   import frtm_pkg::*;
;
   // A short tick keeps timer runs brief; expectations scale with it.
   localparam int TICK = 10;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic duty_update = 1'b0;
   logic [2:0][7:0] target_duty = 24'h000000;
   logic cpu_throttle_in_n;
   logic [2:0][7:0] pwm_duty;
   logic fan_full_on;
   logic bus_alert_n;
   int num_errors = 0;
   int n_checks = 0;
   logic [7:0] st [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C,
      8'h18, 8'h30};

   // The clock toggles every half period of 200 MHz.
   always #2.5 clk = ~clk;

   frtm_top #(.TICK_CYCLES(TICK)) frtm_top_i (
      .clk(clk),
      .sys_rst(sys_rst),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .duty_update(duty_update),
      .target_duty(target_duty),
      .cpu_throttle_in_n(cpu_throttle_in_n),
      .pwm_duty(pwm_duty),
      .fan_full_on(fan_full_on),
      .bus_alert_n(bus_alert_n)
   );

   frtm_cpu_model frtm_cpu_model_i (
      .clk(clk),
      .cpu_throttle_in_n(cpu_throttle_in_n)
   );

   // Prints the verdict and stops the run.
   task automatic end_sim();
      if (num_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Compares one byte; case inequality so an unknown never matches.
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One register write: strobe for a single edge, then drop it.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
   endtask

   // One register read; the data holds, so it is sampled an edge later.
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
      input string nm);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      @(posedge clk);
      #1;
      chk(nm, e, reg_rdata);
   endtask

   // One duty update pulse, then a check of all three outputs.
   task automatic upd3(input logic [2:0][7:0] t,
      input logic [2:0][7:0] e);
      @(posedge clk);
      #1;
      target_duty = t;
      duty_update = 1'b1;
      @(posedge clk);
      #1;
      duty_update = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("duty1", e[0], pwm_duty[0]);
      chk("duty2", e[1], pwm_duty[1]);
      chk("duty3", e[2], pwm_duty[2]);
   endtask

   // Throttle pulse with a look at the outputs while the pin is low.
   task automatic thr(input int n, input logic full, input logic alert);
      fork
         frtm_cpu_model_i.hold_low(n);
         begin
            repeat (20) @(posedge clk);
            #2;
            chk("full_on", {7'h00, full}, {7'h00, fan_full_on});
            chk("duty1_low", full ? DUTY_FULL : 8'h40, pwm_duty[0]);
            chk("duty3_low", full ? DUTY_FULL : 8'h40, pwm_duty[2]);
            chk("alert_low", {7'h00, alert}, {7'h00, bus_alert_n});
         end
      join
      repeat (8) @(posedge clk);
      #1;
   endtask

   // Reset values, and writes to read-only or unmapped places ignored.
   task automatic t_reset();
      chk("rst_duty1", RST_DUTY, pwm_duty[0]);
      chk("rst_duty2", RST_DUTY, pwm_duty[1]);
      chk("rst_duty3", RST_DUTY, pwm_duty[2]);
      chk("rst_alert", 8'h01, {7'h00, bus_alert_n});
      chk("rst_full", 8'h00, {7'h00, fan_full_on});
      wr(ADDR_THROTTLE_STATUS, 8'hFF);
      wr(ADDR_INT_STATUS_TWO, 8'hFF);
      wr(8'h10, 8'hFF);
      rd(ADDR_ACOUSTIC_ONE, 8'h00, "ac1");
      rd(ADDR_ACOUSTIC_TWO, 8'h00, "ac2");
      rd(ADDR_THROTTLE_MASK, 8'h00, "mask");
      rd(ADDR_THROTTLE_STATUS, 8'h00, "status");
      rd(ADDR_INT_STATUS_TWO, 8'h00, "int2");
      rd(8'h10, 8'h00, "unmapped");
   endtask

   // Every step code on every channel, with codes offset per channel
   // so that a swapped field shows up as a wrong step.
   task automatic t_ramp();
      logic [2:0] k1;
      logic [2:0] k2;
      logic [2:0] k3;
      for (int c = 0; c < 8; c++) begin
         k1 = 3'(c);
         k2 = k1 + 3'h3;
         k3 = k1 + 3'h5;
         wr(ADDR_ACOUSTIC_ONE, 8'h00);
         wr(ADDR_ACOUSTIC_TWO, 8'h00);
         upd3(24'h404040, 24'h404040);
         wr(ADDR_ACOUSTIC_ONE, {5'h01, k1});
         wr(ADDR_ACOUSTIC_TWO, {1'b1, k2, 1'b1, k3});
         rd(ADDR_ACOUSTIC_TWO, {1'b1, k2, 1'b1, k3}, "ac2_rw");
         upd3(24'h808080, {8'h40 + st[k3], 8'h40 + st[k2],
            8'h40 + st[k1]});
         upd3(24'h000000, 24'h404040);
         upd3(24'h414141, 24'h414141);
         upd3(24'h404040, 24'h404040);
      end
   endtask

   // Long assertion with fan_full_on_throttle: flags, timer and long flag all show.
   task automatic t_long();
      wr(ADDR_CONFIG_THREE, 8'h06);
      wr(ADDR_THROTTLE_MASK, 8'h03);
      thr(10 * TICK / 2 + 5, 1'b1, 1'b0);
      chk("duty_back", 8'h40, pwm_duty[1]);
      rd(ADDR_THROTTLE_STATUS, 8'hC5, "status");
      chk("alert_clr", 8'h01, {7'h00, bus_alert_n});
      rd(ADDR_THROTTLE_STATUS, 8'h05, "status_rc");
      rd(ADDR_INT_STATUS_TWO, 8'h20, "long");
      rd(ADDR_INT_STATUS_TWO, 8'h00, "long_rc");
   endtask

   // Edge alerts masked: short pulse stays quiet, long one still alerts.
   task automatic t_masked();
      wr(ADDR_CONFIG_THREE, 8'h02);
      wr(ADDR_THROTTLE_MASK, 8'hCA);
      thr(2 * TICK + 5, 1'b0, 1'b1);
      chk("alert_mask", 8'h01, {7'h00, bus_alert_n});
      rd(ADDR_THROTTLE_STATUS, 8'hC2, "status_short");
      rd(ADDR_INT_STATUS_TWO, 8'h00, "long_short");
      wr(ADDR_THROTTLE_MASK, 8'hC1);
      thr(3 * TICK + 5, 1'b0, 1'b1);
      chk("alert_long", 8'h00, {7'h00, bus_alert_n});
      rd(ADDR_THROTTLE_STATUS, 8'hC3, "status_long");
      rd(ADDR_INT_STATUS_TWO, 8'h20, "long_set");
      // Only the assertion edge masked: the release alone must alert,
      // which catches the two mask bits being swapped.
      wr(ADDR_THROTTLE_MASK, 8'hBF);
      thr(2 * TICK + 5, 1'b0, 1'b1);
      chk("alert_rel", 8'h00, {7'h00, bus_alert_n});
      rd(ADDR_THROTTLE_STATUS, 8'hC2, "status_rel");
   endtask

   // Timer saturation at the top limit, then a deselected input.
   task automatic t_sat();
      wr(ADDR_CONFIG_THREE, 8'h06);
      wr(ADDR_THROTTLE_MASK, 8'h3F);
      thr(70 * TICK, 1'b1, 1'b0);
      rd(ADDR_THROTTLE_STATUS, 8'hFF, "status_sat");
      rd(ADDR_INT_STATUS_TWO, 8'h00, "long_eq");
      wr(ADDR_CONFIG_THREE, 8'h00);
      thr(3 * TICK, 1'b0, 1'b1);
      rd(ADDR_THROTTLE_STATUS, 8'h3F, "status_off");
   endtask

   // Main sequence: reset for three clocks, then every scenario.
   initial begin
      repeat (3) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_reset();
      t_ramp();
      t_long();
      t_masked();
      t_sat();
      end_sim();
   end

   // Watchdog: the scenarios need a few thousand clocks at most.
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_sim();
   end
endmodule
